// ===== rtl/fepc_pkg.sv
package fepc_pkg;

  // register byte offsets
  localparam logic [7:0] FEPC_OFS_OPCTRL   = 8'h00;
  localparam logic [7:0] FEPC_OFS_KEY      = 8'h04;
  localparam logic [7:0] FEPC_OFS_ADDR_LO  = 8'h08;
  localparam logic [7:0] FEPC_OFS_ADDR_HI  = 8'h0C;
  localparam logic [7:0] FEPC_OFS_SRC_PTR  = 8'h10;
  localparam logic [7:0] FEPC_OFS_DATA_LO  = 8'h14;
  localparam logic [7:0] FEPC_OFS_DATA_HI  = 8'h18;
  localparam logic [7:0] FEPC_OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] FEPC_OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] FEPC_OFS_SBE_PRIO = 8'h24;
  localparam logic [7:0] FEPC_OFS_TRAP_CFG = 8'h28;

  // field positions
  localparam int FEPC_OPCTRL_START = 15;
  localparam int FEPC_IRQ_SBE      = 0;
  localparam int FEPC_IRQ_DONE     = 1;
  localparam int FEPC_IRQ_REFUSED  = 2;

  // unlock keys
  localparam logic [7:0] FEPC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FEPC_KEY_SECOND = 8'hAA;

  // widths and reset values
  localparam int FEPC_DATA_W   = 48;
  localparam int FEPC_ECC_W    = 7;
  localparam int FEPC_WORD_W   = 24;
  localparam int FEPC_ADDR_W   = 24;
  localparam int FEPC_IRQ_W    = 3;
  localparam int FEPC_PAIR_STEP = 4;
  localparam logic [2:0] FEPC_PRIO_RST = 3'h0;

  typedef enum logic [1:0] {
    FEPC_OP_PAGE_ERASE  = 2'h0,
    FEPC_OP_WORD_PROG   = 2'h1,
    FEPC_OP_ROW_PROG    = 2'h2,
    FEPC_OP_PANEL_ERASE = 2'h3
  } fepc_op_t;

  typedef enum logic [1:0] {
    FEPC_UNL_NONE  = 2'h0,
    FEPC_UNL_FIRST = 2'h1,
    FEPC_UNL_ARMED = 2'h2
  } fepc_unl_t;

  typedef enum logic [5:0] {
    FEPC_ST_IDLE     = 6'b000001,
    FEPC_ST_FETCH_LO = 6'b000010,
    FEPC_ST_FETCH_HI = 6'b000100,
    FEPC_ST_WRITE    = 6'b001000,
    FEPC_ST_WAIT     = 6'b010000,
    FEPC_ST_ERASE    = 6'b100000
  } fepc_st_t;

endpackage : fepc_pkg

// ===== rtl/fepc_ecc_enc.sv
`timescale 1ns/1ps
module fepc_ecc_enc #(
  parameter int DW = 48
) (
  // data and check bits
  input  wire logic [DW-1:0] data,
  output logic      [6:0]    ecc
);
  // data sits at the codeword positions that are not powers of two
  always_comb begin
    logic [5:0] c;
    int k;
    c = 6'h00;
    k = 0;
    for (int p = 1; p <= DW + 6; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (data[k]) begin
          c = c ^ 6'(p);
        end
        k = k + 1;
      end
    end
    // overall bit makes the full codeword even, giving double detection
    ecc = {(^data) ^ (^c), c};
  end
endmodule : fepc_ecc_enc

// ===== rtl/fepc_ecc_dec.sv
`timescale 1ns/1ps
module fepc_ecc_dec #(
  parameter int DW = 48
) (
  // fetched block
  input  wire logic [DW-1:0] data,
  input  wire logic [6:0]    ecc_stored,
  input  wire logic [6:0]    ecc_calc,
  // result
  output logic      [DW-1:0] data_out,
  output logic               sbe,
  output logic               dbe
);
  logic [5:0] syn;
  logic       odd;

  assign syn = ecc_stored[5:0] ^ ecc_calc[5:0];
  assign odd = (^data) ^ (^ecc_stored);

  always_comb begin
    int k;
    k = 0;
    data_out = data;
    sbe = odd;
    dbe = (syn != 6'h00) && !odd;
    for (int p = 1; p <= DW + 6; p++) begin
      if ((p & (p - 1)) != 0) begin
        // double errors pass through untouched
        if (odd && (syn == 6'(p))) begin
          data_out[k] = ~data[k];
        end
        k = k + 1;
      end
    end
  end
endmodule : fepc_ecc_dec

// ===== rtl/fepc_top.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01 - write: 7-bit parity per word pair
// RULE_02 - 48 data plus 7 hidden parity
// RULE_03 - read: recompute parity, compare stored
// RULE_04 - single error: correct data automatically
// RULE_05 - corrected error sets sticky interrupt flag
// RULE_06 - software enables interrupt, programs priority
// RULE_07 - double error: hard trap, data unchanged
// RULE_08 - no trap handler: also reset
// RULE_09 - error correction can never be disabled
// RULE_10 - no hardware error logging or counting
// RULE_11 - control register selects and starts operation
// RULE_12 - write-only key: 0x55 then 0xAA
// RULE_13 - target address: high 8, low 16
// RULE_14 - row data fetched from RAM pointer
// RULE_15 - start only right after full unlock; a non-start control write in between keeps the unlock
// RULE_16 - unlock cleared after start or mismatch
module fepc_top #(
  parameter int ROW_PAIRS = 64
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // instruction fetch port
  input  wire logic                          if_req,
  input  wire logic [fepc_pkg::FEPC_ADDR_W-1:0] if_addr,
  output logic                               if_ready,
  output logic                               if_rvalid,
  output logic      [fepc_pkg::FEPC_DATA_W-1:0] if_rdata,
  output logic                               if_sbe,
  // traps, reset and interrupt
  output logic                               hard_trap,
  output logic                               dev_reset_req,
  output logic                               irq,
  output logic      [2:0]                    sbe_irq_priority,
  // data ram read port for row programming
  output logic                               ram_re,
  output logic      [15:0]                   ram_addr,
  input  wire logic [fepc_pkg::FEPC_WORD_W-1:0] ram_rdata,
  // flash array
  output logic                               fl_rd,
  output logic                               fl_wr,
  output logic                               fl_erase,
  output logic                               fl_erase_panel,
  output logic      [fepc_pkg::FEPC_ADDR_W-1:0] fl_addr,
  output logic      [fepc_pkg::FEPC_DATA_W-1:0] fl_wdata,
  output logic      [fepc_pkg::FEPC_ECC_W-1:0]  fl_wecc,
  input  wire logic                          fl_rvalid,
  input  wire logic [fepc_pkg::FEPC_DATA_W-1:0] fl_rdata,
  input  wire logic [fepc_pkg::FEPC_ECC_W-1:0]  fl_recc,
  input  wire logic                          fl_done
);
  import fepc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay

  logic            dp_wr_r;
  logic [7:0]      dp_addr_r;
  logic            wr_en;
  logic [1:0]      op_kind_r;
  fepc_unl_t       unlock_r;
  fepc_st_t        st_r;
  logic [15:0]     addr_lo_r;
  logic [7:0]      addr_hi_r;
  logic [15:0]     src_ptr_r;
  logic [FEPC_WORD_W-1:0] data_lo_r;
  logic [FEPC_WORD_W-1:0] data_hi_r;
  logic [FEPC_IRQ_W-1:0]  irq_stat_r;
  logic [FEPC_IRQ_W-1:0]  irq_mask_r;
  logic [2:0]      prio_r;
  logic            handler_en_r;
  logic            op_start;
  logic            op_refused;
  logic            op_done;
  logic            rd_sbe;
  logic            rd_dbe;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dp_wr_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready) begin
      dp_wr_r   <= hsel && htrans[1] && hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  // read data built from flops; key register always reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    case (dp_addr_r)
      FEPC_OFS_OPCTRL:   hrdata = {16'h0000, (st_r != FEPC_ST_IDLE), 13'h0000, op_kind_r};
      FEPC_OFS_ADDR_LO:  hrdata = {16'h0000, addr_lo_r};
      FEPC_OFS_ADDR_HI:  hrdata = {24'h00_0000, addr_hi_r};
      FEPC_OFS_SRC_PTR:  hrdata = {16'h0000, src_ptr_r};
      FEPC_OFS_DATA_LO:  hrdata = {8'h00, data_lo_r};
      FEPC_OFS_DATA_HI:  hrdata = {8'h00, data_hi_r};
      FEPC_OFS_IRQ_STAT: hrdata = {29'h0000_0000, irq_stat_r};
      FEPC_OFS_IRQ_MASK: hrdata = {29'h0000_0000, irq_mask_r};
      FEPC_OFS_SBE_PRIO: hrdata = {29'h0000_0000, prio_r};
      FEPC_OFS_TRAP_CFG: hrdata = {31'h0000_0000, handler_en_r};
      default:           hrdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain configuration registers

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_lo_r    <= 16'h0000;
      addr_hi_r    <= 8'h00;
      src_ptr_r    <= 16'h0000;
      data_lo_r    <= 24'h00_0000;
      data_hi_r    <= 24'h00_0000;
      irq_mask_r   <= 3'h0;
      prio_r       <= FEPC_PRIO_RST;
      handler_en_r <= 1'b0;
    end else if (wr_en) begin
      case (dp_addr_r)
        FEPC_OFS_ADDR_LO:  addr_lo_r    <= hwdata[15:0];  // RULE_13
        FEPC_OFS_ADDR_HI:  addr_hi_r    <= hwdata[7:0];   // RULE_13
        FEPC_OFS_SRC_PTR:  src_ptr_r    <= hwdata[15:0];
        FEPC_OFS_DATA_LO:  data_lo_r    <= hwdata[FEPC_WORD_W-1:0];
        FEPC_OFS_DATA_HI:  data_hi_r    <= hwdata[FEPC_WORD_W-1:0];
        FEPC_OFS_IRQ_MASK: irq_mask_r   <= hwdata[FEPC_IRQ_W-1:0];
        FEPC_OFS_SBE_PRIO: prio_r       <= hwdata[2:0];
        FEPC_OFS_TRAP_CFG: handler_en_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  assign sbe_irq_priority = prio_r;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence and start

  logic       start_wr;
  logic [1:0] start_kind;
  assign start_wr   = wr_en && (dp_addr_r == FEPC_OFS_OPCTRL) && hwdata[FEPC_OPCTRL_START];
  // the start write carries the kind it starts; the kind register takes it at that same edge
  assign start_kind = hwdata[1:0];  // RULE_11
  // a busy sequencer cannot be restarted, even when armed
  assign op_start   = start_wr && (unlock_r == FEPC_UNL_ARMED) && (st_r == FEPC_ST_IDLE);  // RULE_15
  assign op_refused = start_wr && !op_start;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unlock_r <= FEPC_UNL_NONE;
    end else if (wr_en) begin
      // any write other than the expected key or a non-start control write while armed drops the unlock
      if (dp_addr_r == FEPC_OFS_KEY && hwdata[7:0] == FEPC_KEY_FIRST) begin
        unlock_r <= FEPC_UNL_FIRST;  // RULE_12
      end else if (dp_addr_r == FEPC_OFS_KEY && hwdata[7:0] == FEPC_KEY_SECOND &&
                   unlock_r == FEPC_UNL_FIRST) begin
        unlock_r <= FEPC_UNL_ARMED;  // RULE_12
      end else if (dp_addr_r == FEPC_OFS_OPCTRL && !hwdata[FEPC_OPCTRL_START] &&
                   unlock_r == FEPC_UNL_ARMED) begin
        // setting up the operation kind keeps the unlock
        unlock_r <= FEPC_UNL_ARMED;
      end else begin
        unlock_r <= FEPC_UNL_NONE;  // RULE_16
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_kind_r <= FEPC_OP_PAGE_ERASE;
    end else if (wr_en && dp_addr_r == FEPC_OFS_OPCTRL && st_r == FEPC_ST_IDLE) begin
      op_kind_r <= hwdata[1:0];  // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program and erase sequencer

  logic [$clog2(ROW_PAIRS+1)-1:0] pair_cnt_r;
  logic [FEPC_WORD_W-1:0]         lo_buf_r;
  logic [FEPC_WORD_W-1:0]         hi_buf_r;
  logic [FEPC_ECC_W-1:0]          wr_ecc_pair;
  logic [FEPC_ADDR_W-1:0]         target;

  assign target = {addr_hi_r, addr_lo_r};  // RULE_13
  assign op_done = (st_r == FEPC_ST_WAIT || st_r == FEPC_ST_ERASE) && fl_done &&
                   !(st_r == FEPC_ST_WAIT && op_kind_r == FEPC_OP_ROW_PROG &&
                     pair_cnt_r != ($clog2(ROW_PAIRS+1))'(ROW_PAIRS));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= FEPC_ST_IDLE;
      pair_cnt_r <= '0;
      lo_buf_r   <= 24'h00_0000;
      hi_buf_r   <= 24'h00_0000;
      ram_addr   <= 16'h0000;
    end else begin
      case (st_r)
        FEPC_ST_IDLE: begin
          pair_cnt_r <= '0;
          ram_addr   <= src_ptr_r;  // RULE_14
          if (op_start) begin
            case (start_kind)
              FEPC_OP_WORD_PROG: begin
                lo_buf_r <= data_lo_r;
                hi_buf_r <= data_hi_r;
                st_r     <= FEPC_ST_WRITE;
              end
              FEPC_OP_ROW_PROG: st_r <= FEPC_ST_FETCH_LO;  // RULE_14
              default:          st_r <= FEPC_ST_ERASE;     // RULE_11
            endcase
          end
        end
        FEPC_ST_FETCH_LO: begin
          ram_addr <= ram_addr + 16'h0001;
          st_r     <= FEPC_ST_FETCH_HI;
        end
        FEPC_ST_FETCH_HI: begin
          // ram answers one cycle after its read strobe
          lo_buf_r <= ram_rdata;
          ram_addr <= ram_addr + 16'h0001;
          st_r     <= FEPC_ST_WRITE;
        end
        FEPC_ST_WRITE: begin
          if (op_kind_r == FEPC_OP_ROW_PROG) begin
            hi_buf_r <= ram_rdata;
          end
          pair_cnt_r <= pair_cnt_r + 1'b1;
          st_r       <= FEPC_ST_WAIT;
        end
        FEPC_ST_WAIT: begin
          if (fl_done) begin
            if (op_kind_r == FEPC_OP_ROW_PROG &&
                pair_cnt_r != ($clog2(ROW_PAIRS+1))'(ROW_PAIRS)) begin
              st_r <= FEPC_ST_FETCH_LO;
            end else begin
              st_r <= FEPC_ST_IDLE;
            end
          end
        end
        FEPC_ST_ERASE: begin
          if (fl_done) begin
            st_r <= FEPC_ST_IDLE;
          end
        end
        default: st_r <= FEPC_ST_IDLE;
      endcase
    end
  end

  assign ram_re = (st_r == FEPC_ST_FETCH_LO) || (st_r == FEPC_ST_FETCH_HI);

  // word pair in flight; the high word of a row pair arrives as WRITE begins
  logic [FEPC_WORD_W-1:0] hi_word;
  assign hi_word = (op_kind_r == FEPC_OP_ROW_PROG) ? ram_rdata : hi_buf_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fl_wr          <= 1'b0;
      fl_erase       <= 1'b0;
      fl_erase_panel <= 1'b0;
      fl_addr        <= 24'h00_0000;
      fl_wdata       <= 48'h0000_0000_0000;
      fl_rd          <= 1'b0;
    end else begin
      fl_wr    <= 1'b0;
      fl_erase <= 1'b0;
      fl_rd    <= 1'b0;
      if (st_r == FEPC_ST_IDLE && op_start &&
          (start_kind == FEPC_OP_PAGE_ERASE || start_kind == FEPC_OP_PANEL_ERASE)) begin
        fl_erase       <= 1'b1;
        fl_erase_panel <= (start_kind == FEPC_OP_PANEL_ERASE);  // RULE_11
        fl_addr        <= target;  // RULE_13
      end else if (st_r == FEPC_ST_WRITE) begin
        fl_wr    <= 1'b1;
        fl_wdata <= {hi_word, lo_buf_r};  // RULE_02
        fl_addr  <= target + 24'(pair_cnt_r) * 24'(FEPC_PAIR_STEP);
      end else if (st_r == FEPC_ST_IDLE && if_req && !op_start) begin
        fl_rd   <= 1'b1;
        fl_addr <= if_addr;
      end
    end
  end

  // parity of the stored pair, registered with the data it covers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fl_wecc <= 7'h00;
    end else if (st_r == FEPC_ST_WRITE) begin
      fl_wecc <= wr_ecc_pair;  // RULE_01
    end
  end

  fepc_ecc_enc #(.DW(FEPC_DATA_W)) u_enc_pair (
    .data ({hi_word, lo_buf_r}),
    .ecc  (wr_ecc_pair)
  );

  assign if_ready = (st_r == FEPC_ST_IDLE) && !op_start;

  ////////////////////////////////////////////////////////////////////////////
  // read check and correction, always on with no bypass

  logic [FEPC_ECC_W-1:0]  rd_ecc;
  logic [FEPC_DATA_W-1:0] rd_fixed;

  fepc_ecc_enc #(.DW(FEPC_DATA_W)) u_enc_rd (
    .data (fl_rdata),
    .ecc  (rd_ecc)  // RULE_03
  );

  fepc_ecc_dec #(.DW(FEPC_DATA_W)) u_dec (
    .data       (fl_rdata),
    .ecc_stored (fl_recc),
    .ecc_calc   (rd_ecc),
    .data_out   (rd_fixed),
    .sbe        (rd_sbe),
    .dbe        (rd_dbe)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      if_rvalid     <= 1'b0;
      if_rdata      <= 48'h0000_0000_0000;
      if_sbe        <= 1'b0;
      hard_trap     <= 1'b0;
      dev_reset_req <= 1'b0;
    end else begin
      if_rvalid     <= fl_rvalid;          // RULE_09
      if_sbe        <= fl_rvalid && rd_sbe;
      hard_trap     <= fl_rvalid && rd_dbe;  // RULE_07
      // without a trap handler the double error also resets the device
      dev_reset_req <= fl_rvalid && rd_dbe && !handler_en_r;  // RULE_08
      if (fl_rvalid) begin
        if_rdata <= rd_fixed;  // RULE_04
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins; nothing is counted

  logic [FEPC_IRQ_W-1:0] irq_set;
  logic [FEPC_IRQ_W-1:0] irq_clr;

  assign irq_set = {op_refused, op_done, if_sbe};  // RULE_10
  assign irq_clr = (wr_en && dp_addr_r == FEPC_OFS_IRQ_STAT) ?
                   hwdata[FEPC_IRQ_W-1:0] : 3'h0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;  // RULE_05
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_wr_parity;
    fl_wr |-> (fl_wecc[6] == ((^fl_wdata) ^ (^fl_wecc[5:0])));
  endproperty
  a_wr_parity: assert property (p_wr_parity) else $error("write parity wrong");  // RULE_01

  property p_rd_valid;
    fl_rvalid |=> if_rvalid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");  // RULE_03

  property p_sbe_fix;
    (fl_rvalid && rd_sbe) |=> (if_sbe && !hard_trap);
  endproperty
  a_sbe_fix: assert property (p_sbe_fix) else $error("single error not flagged");  // RULE_04

  property p_sbe_flag;
    if_sbe |=> irq_stat_r[FEPC_IRQ_SBE];
  endproperty
  a_sbe_flag: assert property (p_sbe_flag) else $error("sticky flag not set");  // RULE_05

  property p_dbe_pass;
    (fl_rvalid && rd_dbe) |=> (hard_trap && if_rdata == $past(fl_rdata));
  endproperty
  a_dbe_pass: assert property (p_dbe_pass) else $error("double error mishandled");  // RULE_07

  property p_dbe_reset;
    hard_trap |-> (dev_reset_req == !$past(handler_en_r));
  endproperty
  a_dbe_reset: assert property (p_dbe_reset) else $error("reset request wrong");  // RULE_08

  property p_start_key;
    (st_r == FEPC_ST_IDLE) ##1 (st_r != FEPC_ST_IDLE) |-> $past(unlock_r) == FEPC_UNL_ARMED;
  endproperty
  a_start_key: assert property (p_start_key) else $error("start without unlock");  // RULE_15

  property p_key_clear;
    op_start |=> (unlock_r == FEPC_UNL_NONE);
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("unlock not cleared");  // RULE_16

  property p_erase_addr;
    fl_erase |-> (fl_addr == {addr_hi_r, addr_lo_r});
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase address wrong");  // RULE_13

  property p_row_ptr;
    (st_r == FEPC_ST_IDLE) ##1 (st_r == FEPC_ST_FETCH_LO) |-> ram_addr == $past(src_ptr_r);
  endproperty
  a_row_ptr: assert property (p_row_ptr) else $error("row fetch pointer wrong");  // RULE_14

  c_sbe:   cover property (fl_rvalid && rd_sbe);
  c_dbe:   cover property (fl_rvalid && rd_dbe);
  c_row:   cover property (op_start && start_kind == FEPC_OP_ROW_PROG);
  c_erase: cover property (fl_erase && fl_erase_panel);

endmodule : fepc_top

// ===== verif/fepc_flash_model.sv
`timescale 1ns/1ps
module fepc_flash_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // array port
  input  wire logic        fl_rd,
  input  wire logic        fl_wr,
  input  wire logic        fl_erase,
  input  wire logic        fl_erase_panel,
  input  wire logic [23:0] fl_addr,
  input  wire logic [47:0] fl_wdata,
  input  wire logic [6:0]  fl_wecc,
  output logic             fl_rvalid,
  output logic      [47:0] fl_rdata,
  output logic      [6:0]  fl_recc,
  output logic             fl_done,
  // bench control and visibility
  input  wire logic [54:0] err_mask,
  input  wire logic [3:0]  done_lat,
  output logic      [7:0]  n_wr,
  output logic      [7:0]  n_er,
  output logic      [23:0] last_addr,
  output logic             last_panel
);
  logic [54:0] mem [8];
  logic [3:0]  busy_cnt;
  // eight blocks only; enough for the addresses the bench uses
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fl_rvalid <= 1'b0;
      fl_done   <= 1'b0;
      busy_cnt  <= 4'h0;
      n_wr      <= 8'h00;
      n_er      <= 8'h00;
    end else begin
      fl_rvalid <= fl_rd;
      fl_done   <= (busy_cnt == 4'h1);
      // idle data lines toggle so stale values never look valid
      if (fl_rd) {fl_recc, fl_rdata} <= mem[fl_addr[4:2]] ^ err_mask;
      else {fl_recc, fl_rdata} <= ~{fl_recc, fl_rdata};
      if (fl_wr || fl_erase) busy_cnt <= done_lat;
      else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
      if (fl_wr) begin
        mem[fl_addr[4:2]] <= {fl_wecc, fl_wdata};
        n_wr              <= n_wr + 8'h01;
        last_addr         <= fl_addr;
      end
      if (fl_erase) begin
        mem[fl_addr[4:2]] <= '0;
        n_er              <= n_er + 8'h01;
        last_addr         <= fl_addr;
        last_panel        <= fl_erase_panel;
      end
    end
  end
endmodule : fepc_flash_model

// ===== verif/flash_ecc_program_control_test.sv
`timescale 1ns/1ps
module flash_ecc_program_control_test;
  import fepc_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, s;
  logic [1:0] htrans = 2'h0;
  logic if_req = 1'b0, if_ready, if_rvalid, if_sbe, hard_trap, dev_reset_req, irq, ram_re;
  logic [23:0] if_addr = '0, ram_rdata = '0, fl_addr, last_addr;
  logic [47:0] if_rdata, fl_wdata, fl_rdata, f_data;
  logic [2:0] sbe_irq_priority;
  logic [15:0] ram_addr;
  logic fl_rd, fl_wr, fl_erase, fl_erase_panel, fl_rvalid, fl_done, last_panel;
  logic f_sbe, f_trap, f_rst;
  logic [6:0] fl_wecc, fl_recc;
  logic [54:0] err_mask = '0;
  logic [3:0] done_lat = 4'h1;
  logic [7:0] n_wr, n_er;
  int n_errors = 0, n_compared = 0;
  assign hready = hreadyout;
  always #5 mclk = ~mclk;
  // data ram: answers one cycle after the read strobe, toggles otherwise
  always @(posedge mclk) ram_rdata <= ram_re ? {8'h5A, ram_addr} : ~ram_rdata;
  fepc_top #(.ROW_PAIRS(2)) fepc_top_i (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .if_req, .if_addr, .if_ready,
    .if_rvalid, .if_rdata, .if_sbe, .hard_trap, .dev_reset_req, .irq, .sbe_irq_priority,
    .ram_re, .ram_addr, .ram_rdata, .fl_rd, .fl_wr, .fl_erase, .fl_erase_panel, .fl_addr,
    .fl_wdata, .fl_wecc, .fl_rvalid, .fl_rdata, .fl_recc, .fl_done);
  fepc_flash_model fepc_flash_model_i (.mclk, .rstn, .fl_rd, .fl_wr, .fl_erase, .fl_erase_panel,
    .fl_addr, .fl_wdata, .fl_wecc, .fl_rvalid, .fl_rdata, .fl_recc, .fl_done, .err_mask,
    .done_lat, .n_wr, .n_er, .last_addr, .last_panel);
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, s);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, s);
    chk(s, exp);
  endtask : rdc
  task automatic prog(input logic [1:0] op, input logic unlock);
    if (unlock) begin
      wr(FEPC_OFS_KEY, 32'h55);
      wr(FEPC_OFS_KEY, 32'hAA);
    end
    wr(FEPC_OFS_OPCTRL, 32'h8000 | op);
  endtask : prog
  // the done flag is polled; only the watchdog bounds the wait
  task automatic wait_done;
    do ahb(1'b0, FEPC_OFS_IRQ_STAT, 32'h0, s); while (s[FEPC_IRQ_DONE] !== 1'b1);
    wr(FEPC_OFS_IRQ_STAT, 32'h2);
  endtask : wait_done
  task automatic fetch(input logic [23:0] a);
    @(posedge mclk);
    if_req  <= 1'b1;
    if_addr <= a;
    do @(posedge mclk); while (if_ready !== 1'b1);
    if_req <= 1'b0;
    do @(posedge mclk); while (if_rvalid !== 1'b1);
    f_data = if_rdata;
    f_sbe  = if_sbe;
    f_trap = hard_trap;
    f_rst  = dev_reset_req;
  endtask : fetch
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rdc(FEPC_OFS_SBE_PRIO, 32'h0);
    rdc(8'h3C, 32'h0);
    chk({hresp, hreadyout}, 2'b01);
    wr(FEPC_OFS_ADDR_HI, 32'h12);
    wr(FEPC_OFS_ADDR_LO, 32'h0008);
    wr(FEPC_OFS_DATA_LO, 32'hA5A5A5);
    wr(FEPC_OFS_DATA_HI, 32'h3C3C3C);
    prog(2'h1, 1'b1);
    wait_done();
    chk(last_addr, 24'h120008);
    rdc(FEPC_OFS_KEY, 32'h0);
    prog(2'h1, 1'b0);
    rdc(FEPC_OFS_IRQ_STAT, 32'h4);
    wr(FEPC_OFS_IRQ_STAT, 32'h4);
    wr(FEPC_OFS_KEY, 32'h55);
    wr(FEPC_OFS_ADDR_LO, 32'h0008);
    wr(FEPC_OFS_KEY, 32'hAA);
    wr(FEPC_OFS_OPCTRL, 32'h8001);
    wr(FEPC_OFS_KEY, 32'hAA);
    wr(FEPC_OFS_KEY, 32'h55);
    wr(FEPC_OFS_OPCTRL, 32'h8001);
    rdc(FEPC_OFS_IRQ_STAT, 32'h4);
    chk(n_wr, 8'h01);
    wr(FEPC_OFS_IRQ_STAT, 32'h4);
    fetch(24'h120008);
    chk({f_data, f_sbe}, {48'h3C3C3C_A5A5A5, 1'b0});
    // one flipped data bit, then one flipped check bit
    err_mask <= 55'h20;
    fetch(24'h120008);
    chk({f_data, f_sbe, f_trap}, {48'h3C3C3C_A5A5A5, 2'b10});
    rdc(FEPC_OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(FEPC_OFS_IRQ_MASK, 32'h1);
    wr(FEPC_OFS_SBE_PRIO, 32'h5);
    rdc(FEPC_OFS_SBE_PRIO, 32'h5);
    chk({irq, sbe_irq_priority}, 4'hD);
    wr(FEPC_OFS_IRQ_STAT, 32'h1);
    rdc(FEPC_OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    err_mask <= 55'h1 << 50;
    fetch(24'h120008);
    chk({f_data, f_sbe}, {48'h3C3C3C_A5A5A5, 1'b1});
    err_mask <= 55'h220;
    fetch(24'h120008);
    chk({f_data, f_sbe, f_trap, f_rst}, {48'h3C3C3C_A5A785, 3'b011});
    wr(FEPC_OFS_TRAP_CFG, 32'h1);
    fetch(24'h120008);
    chk({f_trap, f_rst}, 2'b10);
    err_mask <= '0;
    // both erase kinds, then a slow two-pair row program
    for (int k = 0; k < 2; k++) begin
      prog(k ? 2'h3 : 2'h0, 1'b1);
      wait_done();
      chk({n_er, last_panel}, {8'(k + 1), k[0]});
    end
    done_lat <= 4'h6;
    wr(FEPC_OFS_ADDR_HI, 32'h0);
    wr(FEPC_OFS_ADDR_LO, 32'h0010);
    wr(FEPC_OFS_SRC_PTR, 32'h0040);
    prog(2'h2, 1'b1);
    wait_done();
    chk({n_wr, last_addr}, {8'h03, 24'h000014});
    fetch(24'h000014);
    chk(f_data, 48'h5A0043_5A0042);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    test_done();
  end
endmodule : flash_ecc_program_control_test
